/* File: src/dect_top.sv */
// Functional notes
// (RQ1) Two counters 0 and 1 exist and a selector picks the one that setup and readback address.
// (RQ2) Each counter increments on a chosen tick, line, user, counter, logic or exposure source.
// (RQ3) Qualifiable count sources count by level low, level high, falling, rising or any edge.
// (RQ4) A start event is raised when the count reaches the delay count.
// (RQ5) An end event is raised when the count reaches the duration count.
// (RQ6) Only one of start-trigger and reset source is active per counter; each turns the other off.
// (RQ7) A counter begins counting when its start-trigger source fires, drawn from the same set.
// (RQ8) The start condition follows its own qualifier when the source is qualifiable.
// (RQ9) A counter is cleared when its reset source fires, drawn from the same set.
// (RQ10) The reset condition follows its own qualifier when the source is qualifiable.
// (RQ11) Live count and status of the selected counter are readable.
// (RQ12) On each counter reset the value just before is captured and held for readback.
// (RQ13) The off choice of any selector never fires.
// (RQ14) The microsecond tick is a one-cycle pulse once every microsecond.
// (RQ15) Start and end events are one-cycle pulses usable by either counter next cycle.
`default_nettype none
module dect_top
   import dect_pkg::*;
#(
   parameter int CNT_W = DEFAULT_CNT_W
) (
   input wire logic mclk,
   input wire logic reset,
   input wire logic [3:0] line_in,
   input wire logic [3:0] user_out,
   input wire logic [1:0] logic_block,
   input wire logic exposure_start,
   input wire logic exposure_end,
   input wire logic awaiting_frame_trigger,
   input wire logic ctr_index_select,
   input wire logic cfg_write,
   input wire logic cfg_start_write,
   input wire logic cfg_reset_write,
   input wire logic [SRC_W-1:0] count_source_select,
   input wire logic [QUAL_W-1:0] count_qualifier,
   input wire logic [CNT_W-1:0] start_delay_count,
   input wire logic [CNT_W-1:0] end_duration_count,
   input wire logic [SRC_W-1:0] start_trigger_select,
   input wire logic [QUAL_W-1:0] start_trigger_qualifier,
   input wire logic [SRC_W-1:0] reset_source_select,
   input wire logic [QUAL_W-1:0] reset_qualifier,
   output logic [CNT_W-1:0] live_count,
   output logic [1:0] ctr_state,
   output logic [CNT_W-1:0] captured_count_on_reset,
   output logic [SRC_W-1:0] active_start_select,
   output logic [SRC_W-1:0] active_reset_select,
   output logic microsecond_tick,
   output logic [1:0] ctr_start_event,
   output logic [1:0] ctr_end_event
);

   if (CNT_W < 2 || CNT_W > 64) begin : g_bad_width
      $error("CNT_W out of range");
   end

   localparam int TICK_W = $clog2(TICK_CYCLES);

   // ************************************************************
   // Microsecond tick.
   // ************************************************************
   logic [TICK_W-1:0] tick_div;

   always_ff @(posedge mclk) begin
      if (reset) begin
         tick_div <= '0;
         microsecond_tick <= 1'b0;
      end else if (tick_div == TICK_W'(TICK_CYCLES - 1)) begin
         tick_div <= '0;
         microsecond_tick <= 1'b1; // see (RQ14)
      end else begin
         tick_div <= tick_div + TICK_W'(1);
         microsecond_tick <= 1'b0;
      end
   end

   // ************************************************************
   // Source vector and its previous value for edge detection.
   // ************************************************************
   logic [NUM_SRC-1:0] src_vec;
   logic [NUM_SRC-1:0] src_prev;
   logic [1:0] start_ev;
   logic [1:0] end_ev;

   assign src_vec = {awaiting_frame_trigger, exposure_end, exposure_start, logic_block,
                     end_ev, start_ev, user_out, line_in, microsecond_tick, 1'b0};

   always_ff @(posedge mclk) begin
      if (reset) begin
         src_prev <= '0;
      end else begin
         src_prev <= src_vec;
      end
   end

   // Pulse sources fire on their pulse; others follow the qualifier.
   function automatic logic dect_fires(input logic [SRC_W-1:0] sel, input logic [QUAL_W-1:0] q,
                                      input logic [NUM_SRC-1:0] cur,
                                      input logic [NUM_SRC-1:0] prev);
      logic c;
      logic p;
      c = 1'b0;
      p = 1'b0;
      if (sel == SRC_OFF || int'(sel) >= NUM_SRC) begin
         return 1'b0; // see (RQ13)
      end
      c = cur[sel];
      p = prev[sel];
      if (!dect_qualifiable(sel)) begin
         return c;
      end
      unique case (q)
         QUAL_LEVEL_LOW: return !c;
         QUAL_LEVEL_HIGH: return c;
         QUAL_FALLING: return p && !c;
         QUAL_RISING: return !p && c;
         QUAL_ANY_EDGE: return p != c;
         default: return 1'b0;
      endcase
   endfunction

   // ************************************************************
   // Per-counter configuration and channels.
   // ************************************************************
   logic [CNT_W-1:0] chan_count [2];
   logic [CNT_W-1:0] chan_capt [2];
   logic [1:0] chan_state [2];

   for (genvar i = 0; i < 2; i++) begin : g_ctr
      logic [SRC_W-1:0] cnt_sel;
      logic [QUAL_W-1:0] cnt_q;
      logic [SRC_W-1:0] st_sel;
      logic [QUAL_W-1:0] st_q;
      logic [SRC_W-1:0] rs_sel;
      logic [QUAL_W-1:0] rs_q;
      logic [CNT_W-1:0] delay;
      logic [CNT_W-1:0] duration;
      logic picked;

      assign picked = (ctr_index_select == 1'(i)); // see (RQ1)

      always_ff @(posedge mclk) begin
         if (reset) begin
            cnt_sel <= SRC_OFF;
            cnt_q <= QUAL_RISING;
            delay <= '0;
            duration <= '0;
         end else if (cfg_write && picked) begin
            cnt_sel <= count_source_select;
            cnt_q <= count_qualifier;
            delay <= start_delay_count;
            duration <= end_duration_count;
         end
      end

      // A later start write of a source other than off turns reset off and vice versa.
      always_ff @(posedge mclk) begin
         if (reset) begin
            st_sel <= SRC_OFF;
            st_q <= QUAL_RISING;
            rs_sel <= SRC_OFF;
            rs_q <= QUAL_RISING;
         end else if (picked && cfg_start_write) begin
            st_sel <= start_trigger_select;
            st_q <= start_trigger_qualifier;
            if (start_trigger_select != SRC_OFF) begin
               rs_sel <= SRC_OFF; // see (RQ6)
            end
         end else if (picked && cfg_reset_write) begin
            rs_sel <= reset_source_select;
            rs_q <= reset_qualifier;
            if (reset_source_select != SRC_OFF) begin
               st_sel <= SRC_OFF; // see (RQ6)
            end
         end
      end

      dect_channel #(
         .CNT_W(CNT_W)
      ) u_chan (
         .mclk(mclk),
         .reset(reset),
         .count_hit(dect_fires(cnt_sel, cnt_q, src_vec, src_prev)), // see (RQ3)
         .start_hit(dect_fires(st_sel, st_q, src_vec, src_prev)), // see (RQ8)
         .reset_hit(dect_fires(rs_sel, rs_q, src_vec, src_prev)), // see (RQ10)
         .start_gate_used(st_sel != SRC_OFF),
         .start_delay_count(delay),
         .end_duration_count(duration),
         .live_count(chan_count[i]),
         .captured_count(chan_capt[i]),
         .ctr_state(chan_state[i]),
         .start_event(start_ev[i]),
         .end_event(end_ev[i])
      );
   end

   // ************************************************************
   // Readback of the selected counter, and events of both counters.
   // ************************************************************
   always_ff @(posedge mclk) begin
      if (reset) begin
         live_count <= '0;
         ctr_state <= STATE_IDLE;
         captured_count_on_reset <= '0;
         active_start_select <= SRC_OFF;
         active_reset_select <= SRC_OFF;
         ctr_start_event <= '0;
         ctr_end_event <= '0;
      end else begin
         live_count <= chan_count[ctr_index_select]; // see (RQ11)
         ctr_state <= chan_state[ctr_index_select]; // see (RQ11)
         captured_count_on_reset <= chan_capt[ctr_index_select]; // see (RQ12)
         active_start_select <= ctr_index_select ? g_ctr[1].st_sel : g_ctr[0].st_sel;
         active_reset_select <= ctr_index_select ? g_ctr[1].rs_sel : g_ctr[0].rs_sel;
         ctr_start_event <= start_ev; // see (RQ15)
         ctr_end_event <= end_ev; // see (RQ15)
      end
   end

endmodule // dect_top
`default_nettype wire

/* File: src/dect_pkg.sv */
`default_nettype none
package dect_pkg;

   // ************************************************************
   // Source selection codes, shared by count, start and reset selectors.
   // ************************************************************
   localparam int SRC_W = 5;
   localparam logic [4:0] SRC_OFF = 5'h00;
   localparam logic [4:0] SRC_TICK = 5'h01;
   localparam logic [4:0] SRC_LINE0 = 5'h02;
   localparam logic [4:0] SRC_USER0 = 5'h06;
   localparam logic [4:0] SRC_CTR0_START = 5'h0A;
   localparam logic [4:0] SRC_CTR1_START = 5'h0B;
   localparam logic [4:0] SRC_CTR0_END = 5'h0C;
   localparam logic [4:0] SRC_CTR1_END = 5'h0D;
   localparam logic [4:0] SRC_LOGIC0 = 5'h0E;
   localparam logic [4:0] SRC_EXP_START = 5'h10;
   localparam logic [4:0] SRC_EXP_END = 5'h11;
   localparam logic [4:0] SRC_FRAME_WAIT = 5'h12;
   localparam int NUM_SRC = 19;

   // ************************************************************
   // Qualifier codes.
   // ************************************************************
   localparam int QUAL_W = 3;
   localparam logic [2:0] QUAL_LEVEL_LOW = 3'h0;
   localparam logic [2:0] QUAL_LEVEL_HIGH = 3'h1;
   localparam logic [2:0] QUAL_FALLING = 3'h2;
   localparam logic [2:0] QUAL_RISING = 3'h3;
   localparam logic [2:0] QUAL_ANY_EDGE = 3'h4;

   // ************************************************************
   // Timing.
   // ************************************************************
   localparam int CLK_MHZ = 100;
   localparam int TICK_PERIOD_US = 1;
   localparam int TICK_CYCLES = CLK_MHZ * TICK_PERIOD_US;

   // ************************************************************
   // Default counter width and counter states.
   // ************************************************************
   localparam int DEFAULT_CNT_W = 32;
   localparam logic [1:0] STATE_IDLE = 2'h0;
   localparam logic [1:0] STATE_ACTIVE = 2'h1;
   localparam logic [1:0] STATE_COMPLETED = 2'h2;

   typedef enum logic [1:0] {
      DECT_IDLE,
      DECT_ACTIVE,
      DECT_COMPLETED
   } dect_state_t;

   // True when the source's signal is qualified by level or edge.
   function automatic logic dect_qualifiable(input logic [4:0] sel);
      return (sel != SRC_OFF) && (sel != SRC_TICK) && (sel != SRC_CTR0_START)
         && (sel != SRC_CTR1_START) && (sel != SRC_CTR0_END) && (sel != SRC_CTR1_END);
   endfunction

endpackage
`default_nettype wire

/* File: src/dect_channel.sv */
`default_nettype none
module dect_channel
   import dect_pkg::*;
#(
   parameter int CNT_W = DEFAULT_CNT_W
) (
   input wire logic mclk,
   input wire logic reset,
   input wire logic count_hit,
   input wire logic start_hit,
   input wire logic reset_hit,
   input wire logic start_gate_used,
   input wire logic [CNT_W-1:0] start_delay_count,
   input wire logic [CNT_W-1:0] end_duration_count,
   output logic [CNT_W-1:0] live_count,
   output logic [CNT_W-1:0] captured_count,
   output logic [1:0] ctr_state,
   output logic start_event,
   output logic end_event
);

   dect_state_t state;
   logic [CNT_W-1:0] next_count;

   assign next_count = live_count + CNT_W'(1);

   // ************************************************************
   // Counting and state.
   // ************************************************************
   always_ff @(posedge mclk) begin
      start_event <= 1'b0;
      end_event <= 1'b0;
      if (reset) begin
         state <= DECT_IDLE;
         live_count <= '0;
      end else if (reset_hit) begin
         live_count <= '0; // see (RQ9)
         state <= DECT_ACTIVE;
      end else begin
         unique case (state)
            DECT_IDLE: begin
               // Without a start trigger the counter runs free from reset.
               if (!start_gate_used || start_hit) begin
                  state <= DECT_ACTIVE; // see (RQ7)
               end
            end
            DECT_ACTIVE: begin
               if (count_hit) begin
                  live_count <= next_count; // see (RQ2)
                  if (next_count == start_delay_count) begin
                     start_event <= 1'b1; // see (RQ4) see (RQ15)
                  end
                  if (next_count == end_duration_count) begin
                     end_event <= 1'b1; // see (RQ5) see (RQ15)
                     state <= DECT_COMPLETED;
                  end
               end
            end
            DECT_COMPLETED: begin
               if (start_gate_used && start_hit) begin
                  live_count <= '0;
                  state <= DECT_ACTIVE;
               end
            end
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         captured_count <= '0;
      end else if (reset_hit) begin
         captured_count <= live_count; // see (RQ12)
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         ctr_state <= STATE_IDLE;
      end else begin
         unique case (state)
            DECT_IDLE: ctr_state <= STATE_IDLE;
            DECT_ACTIVE: ctr_state <= STATE_ACTIVE;
            DECT_COMPLETED: ctr_state <= STATE_COMPLETED;
         endcase
      end
   end

endmodule // dect_channel
`default_nettype wire

/* File: verification/dect_monitor.sv */
`default_nettype none
module dect_monitor
   import dect_pkg::*;
#(
   parameter int CNT_W = DEFAULT_CNT_W
) (
   input wire logic mclk,
   input wire logic reset,
   input wire logic ctr_index_select,
   input wire logic cfg_start_write,
   input wire logic cfg_reset_write,
   input wire logic [SRC_W-1:0] start_trigger_select,
   input wire logic [CNT_W-1:0] live_count,
   input wire logic [1:0] ctr_state,
   input wire logic [SRC_W-1:0] active_start_select,
   input wire logic [SRC_W-1:0] active_reset_select,
   input wire logic microsecond_tick,
   input wire logic [1:0] ctr_start_event,
   input wire logic [1:0] ctr_end_event
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (reset);
   // A start-trigger write that is left alone until its readback has settled.
   sequence s_start_cfg;
      cfg_start_write && start_trigger_select != 5'h00 ##1 !cfg_start_write
         && !cfg_reset_write && $stable(ctr_index_select) ##1 $stable(ctr_index_select);
   endsequence
   tick_period_a: assert property (microsecond_tick |-> ##100 microsecond_tick)
      else $error("tick spacing wrong");
   tick_pulse_a: assert property (microsecond_tick |=> !microsecond_tick [*8])
      else $error("tick too wide");
   start_pulse_a: assert property ((ctr_start_event & $past(ctr_start_event)) == 2'h0)
      else $error("start event too wide");
   end_pulse_a: assert property ((ctr_end_event & $past(ctr_end_event)) == 2'h0)
      else $error("end event too wide");
   sel_exclusive_a: assert property (
      active_start_select == 5'h00 || active_reset_select == 5'h00)
      else $error("start and reset sources both active");
   start_cfg_a: assert property (s_start_cfg |-> active_reset_select == 5'h00
      && active_start_select == $past(start_trigger_select, 2))
      else $error("start select write wrong");
   reset_clear_a: assert property ($past(reset) |-> live_count == '0
      && ctr_state == 2'h0 && ctr_start_event == 2'h0 && ctr_end_event == 2'h0)
      else $error("outputs not cleared by reset");
   state_legal_a: assert property (ctr_state != 2'h3)
      else $error("illegal counter state");
endmodule // dect_monitor
bind dect_top dect_monitor #(.CNT_W(CNT_W)) mon (.mclk, .reset, .ctr_index_select,
   .cfg_start_write, .cfg_reset_write, .start_trigger_select, .live_count, .ctr_state,
   .active_start_select, .active_reset_select, .microsecond_tick, .ctr_start_event,
   .ctr_end_event);
`default_nettype wire

/* File: verification/dect_io_model.sv */
`default_nettype none
module dect_io_model (
   input wire logic [12:0] io_req,
   output logic [3:0] line_in,
   output logic [3:0] user_out,
   output logic [1:0] logic_block,
   output logic exposure_start,
   output logic exposure_end,
   output logic awaiting_frame_trigger
);
   timeunit 1ns;
   timeprecision 100ps;
   // The lines are driven hard at both levels, so a request shows at once.
   assign line_in = io_req[3:0];
   assign user_out = io_req[7:4];
   assign logic_block = io_req[9:8];
   assign {awaiting_frame_trigger, exposure_end, exposure_start} = io_req[12:10];
endmodule // dect_io_model
`default_nettype wire

/* File: verification/tb.sv */
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   import dect_pkg::*;
   logic mclk = 1'b0;
   logic reset, ctr_index_select, cfg_write, cfg_start_write, cfg_reset_write;
   logic exposure_start, exposure_end, awaiting_frame_trigger, microsecond_tick;
   logic [12:0] io_req;
   logic [3:0] line_in, user_out;
   logic [1:0] logic_block, ctr_state, ctr_start_event, ctr_end_event;
   logic [SRC_W-1:0] count_source_select, start_trigger_select, reset_source_select;
   logic [SRC_W-1:0] active_start_select, active_reset_select;
   logic [QUAL_W-1:0] count_qualifier, start_trigger_qualifier, reset_qualifier;
   logic [31:0] start_delay_count, end_duration_count, live_count, captured_count_on_reset;
   int mismatches = 0, checked = 0, cycles = 0;
   dect_io_model pins (.io_req, .line_in, .user_out, .logic_block, .exposure_start,
      .exposure_end, .awaiting_frame_trigger);
   dect_top #(.CNT_W(32)) uut (.mclk, .reset, .line_in, .user_out, .logic_block,
      .exposure_start, .exposure_end, .awaiting_frame_trigger, .ctr_index_select,
      .cfg_write, .cfg_start_write, .cfg_reset_write, .count_source_select,
      .count_qualifier, .start_delay_count, .end_duration_count, .start_trigger_select,
      .start_trigger_qualifier, .reset_source_select, .reset_qualifier, .live_count,
      .ctr_state, .captured_count_on_reset, .active_start_select, .active_reset_select,
      .microsecond_tick, .ctr_start_event, .ctr_end_event);
   always #5 mclk = ~mclk;
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 5000) begin
         mismatches++;
         report_and_stop();
      end
   end
   task automatic report_and_stop;
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         $display("BAD %s expected %0h seen %0h", what, exp, got);
         mismatches++;
      end
   endtask
   // Kind 0 loads count fields, 1 the start trigger, 2 the reset source.
   task automatic cfg(input logic idx, input int kind, input logic [4:0] src,
         input logic [2:0] qual, input logic [31:0] dly, input logic [31:0] dur);
      @(negedge mclk);
      ctr_index_select = idx;
      {count_source_select, start_trigger_select, reset_source_select} = {3{src}};
      {count_qualifier, start_trigger_qualifier, reset_qualifier} = {3{qual}};
      start_delay_count = dly;
      end_duration_count = dur;
      {cfg_reset_write, cfg_start_write, cfg_write} = 3'h1 << kind;
      @(negedge mclk);
      {cfg_reset_write, cfg_start_write, cfg_write} = 3'h0;
      repeat (3) @(negedge mclk);
   endtask
   task automatic pulse(input int b, input int len);
      io_req[b] = 1'b1;
      repeat (len) @(negedge mclk);
      io_req[b] = 1'b0;
      repeat (5) @(negedge mclk);
   endtask
   // ****************************************
   // Scenarios.
   // ****************************************
   task automatic t_tick;
      int n;
      n = 0;
      while (microsecond_tick !== 1'b1) @(negedge mclk);
      do begin
         @(negedge mclk);
         n++;
      end while (microsecond_tick !== 1'b1);
      check("tick period", 32'h64, n);
      $display("t_tick done");
   endtask
   task automatic t_end;
      int n;
      logic seen;
      n = 0;
      seen = 1'b0;
      cfg(1, 0, SRC_CTR0_END, QUAL_RISING, 0, 0);
      cfg(0, 0, SRC_TICK, QUAL_RISING, 2, 3);
      while (ctr_end_event[0] !== 1'b1) begin
         @(negedge mclk);
         if (seen) n++;
         if (ctr_start_event[0] === 1'b1) seen = 1'b1;
      end
      check("start to end", 32'h64, n);
      repeat (3) @(negedge mclk);
      check("end state", 32'(STATE_COMPLETED), 32'(ctr_state));
      check("end count", 32'h3, live_count);
      ctr_index_select = 1'b1;
      repeat (3) @(negedge mclk);
      check("chained count", 32'h1, live_count);
      $display("t_end done");
   endtask
   // Four high cycles in a ten-cycle window give each qualifier a known count.
   task automatic t_qual;
      logic [31:0] base;
      logic [31:0] exp [7];
      logic [4:0] src [7];
      int bit_no [7];
      exp = '{32'h6, 32'h4, 32'h1, 32'h1, 32'h2, 32'h0, 32'h0};
      src = '{SRC_LINE0, SRC_LOGIC0, 5'h0F, SRC_EXP_START, SRC_EXP_END, SRC_FRAME_WAIT, SRC_OFF};
      bit_no = '{0, 8, 9, 10, 11, 12, 0};
      for (int i = 0; i < 7; i++) begin
         cfg(1, 0, src[i], i < 6 ? 3'(i) : QUAL_RISING, 0, 0);
         base = live_count;
         pulse(bit_no[i], 4);
         repeat (1) @(negedge mclk);
         check("qualified count", base + exp[i], live_count);
      end
      $display("t_qual done");
   endtask
   task automatic t_reset;
      cfg(1, 1, 5'h04, QUAL_RISING, 0, 0);
      check("start select", 32'h4, 32'(active_start_select));
      cfg(1, 2, 5'h03, QUAL_RISING, 0, 0);
      check("reset select", 32'h3, 32'(active_reset_select));
      check("start cleared", 32'h0, 32'(active_start_select));
      cfg(1, 0, SRC_USER0, QUAL_LEVEL_HIGH, 0, 0);
      pulse(1, 1);
      check("cleared count", 32'h0, live_count);
      pulse(4, 8);
      check("level count", 32'h8, live_count);
      pulse(1, 3);
      check("captured", 32'h8, captured_count_on_reset);
      check("count after reset", 32'h0, live_count);
      $display("t_reset done");
   endtask
   task automatic t_start;
      cfg(0, 2, 5'h08, QUAL_RISING, 0, 0);
      check("reset select set", 32'h8, 32'(active_reset_select));
      cfg(0, 1, 5'h05, QUAL_FALLING, 0, 0);
      check("reset cleared", 32'h0, 32'(active_reset_select));
      check("start select set", 32'h5, 32'(active_start_select));
      cfg(0, 0, 5'h07, QUAL_LEVEL_HIGH, 0, 0);
      io_req[5] = 1'b1;
      io_req[3] = 1'b1;
      repeat (5) @(negedge mclk);
      check("completed count held", 32'h3, live_count);
      io_req[3] = 1'b0;
      repeat (5) @(negedge mclk);
      check("started state", 32'(STATE_ACTIVE), 32'(ctr_state));
      io_req[5] = 1'b0;
      repeat (3) @(negedge mclk);
      check("restarted count", 32'h4, live_count);
      $display("t_start done");
   endtask
   initial begin
      reset = 1'b1;
      io_req = '0;
      ctr_index_select = 1'b0;
      {cfg_write, cfg_start_write, cfg_reset_write} = 3'h0;
      {count_source_select, start_trigger_select, reset_source_select} = '0;
      {count_qualifier, start_trigger_qualifier, reset_qualifier} = '0;
      {start_delay_count, end_duration_count} = '0;
      repeat (20) @(negedge mclk);
      reset = 1'b0;
      t_tick();
      t_end();
      t_qual();
      t_reset();
      t_start();
      report_and_stop();
   end
endmodule // tb
`default_nettype wire
